/* File: verilog/mcuict_table.sv */
// combinational length and cycle table for one opcode
// assumes opcode encodings of the standard 8051 set
`timescale 1ns/100ps
`default_nettype none
module mcuict_table (
  // opcode in
  input  wire logic [7:0] opcode,
  // decoded timing
  output logic [1:0]      len_bytes,
  output logic [3:0]      num_cycles,
  output logic            known
);
  wire [3:0] lo = opcode[3:0];
  wire [3:0] hi = opcode[7:4];
  wire       is_bank = opcode[3];
  wire       is_ind  = (lo[3:1] == 3'h3);
  wire       is_dir  = (lo == 4'h5);
  wire       is_imm  = (lo == 4'h4);
  wire       alu_row = (hi >= 4'h2 && hi <= 4'h6) || hi == 4'h9;
  always_comb begin
    len_bytes  = mcuict_pkg::LEN1;
    num_cycles = mcuict_pkg::CYC1;
    known      = 1'b1;
    if (alu_row && is_bank) begin
      len_bytes = mcuict_pkg::LEN1;
    end else if (alu_row && is_ind) begin
      num_cycles = mcuict_pkg::CYC2;
    end else if (alu_row && (is_dir || is_imm)) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo == 4'h2) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo == 4'h3) begin
      len_bytes  = mcuict_pkg::LEN3;
      num_cycles = mcuict_pkg::CYC3;
    end else if ((hi == 4'h0 || hi == 4'h1) && is_dir) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi == 4'h0 || hi == 4'h1) && is_ind) begin
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi == 4'h0 || hi == 4'h1) && (is_bank || is_imm)) begin
      num_cycles = mcuict_pkg::CYC1;
    end else if (opcode == mcuict_pkg::OP_INC_DP) begin
      num_cycles = mcuict_pkg::CYC1;
    end else if (opcode == mcuict_pkg::OP_MOV_DP
                 || opcode == mcuict_pkg::OP_MOVD_D
                 || opcode == 8'h75) begin
      len_bytes  = mcuict_pkg::LEN3;
      num_cycles = mcuict_pkg::CYC3;
    end else if (opcode == 8'h74) begin
      // immediate to accumulator: opcode plus constant
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if (opcode == mcuict_pkg::OP_CRD_DP
                 || opcode == mcuict_pkg::OP_CRD_PC) begin
      num_cycles = mcuict_pkg::CYC3;
    end else if ((hi == 4'he || hi == 4'hf) && lo[3:2] == 2'h0
                 && lo[1:0] != 2'h1) begin
      num_cycles = mcuict_pkg::CYC3;
    end else if (opcode == mcuict_pkg::OP_PUSH
                 || opcode == mcuict_pkg::OP_POP) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi == 4'hf || hi == 4'hc || hi == 4'h7 || hi == 4'ha
                  || hi == 4'he || hi == 4'h8) && is_bank) begin
      len_bytes  = (hi == 4'h7 || hi == 4'ha || hi == 4'h8)
                   ? mcuict_pkg::LEN2 : mcuict_pkg::LEN1;
      num_cycles = (hi == 4'h7 || hi == 4'ha || hi == 4'h8)
                   ? mcuict_pkg::CYC2 : mcuict_pkg::CYC1;
    end else if ((hi == 4'hf || hi == 4'hc || hi == 4'hd || hi == 4'he)
                 && is_ind) begin
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi == 4'h7 || hi == 4'h8 || hi == 4'ha) && is_ind) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi >= 4'hb) && lo == 4'h2) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if ((hi >= 4'hb) && lo == 4'h3) begin
      num_cycles = mcuict_pkg::CYC1;
    end else if ((hi == 4'hc || hi == 4'he || hi == 4'hf) && is_dir) begin
      len_bytes  = mcuict_pkg::LEN2;
      num_cycles = mcuict_pkg::CYC2;
    end else if (hi == 4'h8 && is_dir) begin
      len_bytes  = mcuict_pkg::LEN3;
      num_cycles = mcuict_pkg::CYC3;
    end else if (opcode == 8'ha4) begin
      num_cycles = mcuict_pkg::CYC_MUL;
    end else if (opcode == 8'h84) begin
      num_cycles = mcuict_pkg::CYC_DIV;
    end else if ((lo == 4'h3 || lo == 4'h4)
                 && opcode != 8'h73 && opcode != 8'hb4) begin
      // indirect jump and compare-jump in these columns are branches
      num_cycles = mcuict_pkg::CYC1;
    end else if (opcode == mcuict_pkg::OP_NOP || opcode == 8'ha5) begin
      num_cycles = mcuict_pkg::CYC1;
    end else begin
      known = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/mcuict_pkg.sv */
// package for the instruction length and cycle decoder
// assumes one system clock; opcodes follow the standard 8051 map
// Summary of operation
// - add_with_carry from bank_register: one byte, one cycle
// - add forms with direct operand: two bytes, two cycles
// - arithmetic on indirect RAM: one byte, two cycles
// - arithmetic with immediate constant: two bytes, two cycles
// - subtract_with_borrow from bank_register: one byte, one cycle
// - inc or dec of direct byte: two bytes, two cycles
// - inc or dec of indirect RAM: one byte, two cycles
// - data_pointer16 increment carries low into high: one byte, one cycle
// - logic op immediate into direct byte: three bytes, three cycles
// - logic op accumulator into direct byte: two bytes, two cycles
// - rotates and accumulator complement: one byte, one cycle
// - move direct to direct: three bytes, three cycles
// - load data_pointer16 immediate: three bytes, three cycles
// - code_memory_read forms: one byte, three cycles
// - external_data_move with 8-bit pointer address: one byte, three cycles
// - external_data_move with data_pointer16 address: one byte, three cycles
// - push and pop of direct byte: two bytes, two cycles
// - store accumulator to indirect RAM: one byte, two cycles
// - exchange accumulator with bank_register: one byte, one cycle
// - low_nibble_exchange swaps bits 3:0 only: one byte, two cycles
// - bit clear/set/complement: two bytes two cycles; carry only one/one
// - cycles generally equal program bytes; no machine-cycle split
// - stack_pointer increments before push write; resets to 0x07
package mcuict_pkg;
  localparam logic [7:0] STK_RESET  = 8'h07;
  localparam logic [7:0] STK_STEP   = 8'h01;
  localparam logic [7:0] OP_PUSH    = 8'hc0;
  localparam logic [7:0] OP_POP     = 8'hd0;
  localparam logic [7:0] OP_INC_DP  = 8'ha3;
  localparam logic [7:0] OP_MOV_DP  = 8'h90;
  localparam logic [7:0] OP_MOVD_D  = 8'h85;
  localparam logic [7:0] OP_CRD_DP  = 8'h93;
  localparam logic [7:0] OP_CRD_PC  = 8'h83;
  localparam logic [7:0] OP_XRD_DP  = 8'he0;
  localparam logic [7:0] OP_XWR_DP  = 8'hf0;
  localparam logic [7:0] OP_CPL_A   = 8'hf4;
  localparam logic [7:0] OP_NOP     = 8'h00;
  localparam logic [1:0] LEN1       = 2'h1;
  localparam logic [1:0] LEN2       = 2'h2;
  localparam logic [1:0] LEN3       = 2'h3;
  localparam logic [3:0] CYC1       = 4'h1;
  localparam logic [3:0] CYC2       = 4'h2;
  localparam logic [3:0] CYC3       = 4'h3;
  localparam logic [3:0] CYC_MUL    = 4'h4;
  localparam logic [3:0] CYC_DIV    = 4'h8;
  typedef enum logic [1:0] {MCUICT_IDLE, MCUICT_BUSY} mcuict_state_t;
endpackage

/* File: verilog/mcuict_ptrs.sv */
// stack pointer and data pointer update unit
// assumes one-cycle update strobes from the sequencer
`timescale 1ns/100ps
`default_nettype none
module mcuict_ptrs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // update strobes
  input  wire logic        push_go,
  input  wire logic        pop_go,
  input  wire logic        dp_inc,
  input  wire logic        dp_load,
  input  wire logic [15:0] dp_value,
  // pointer state
  output logic [7:0]       stack_pointer_ff,
  output logic [15:0]      data_pointer16_ff
);
  wire [7:0] nxt_stack = push_go ? stack_pointer_ff + mcuict_pkg::STK_STEP
                       : pop_go  ? stack_pointer_ff - mcuict_pkg::STK_STEP
                       : stack_pointer_ff;
  wire [15:0] nxt_dp = dp_load ? dp_value
                     : dp_inc  ? data_pointer16_ff + 16'h0001
                     : data_pointer16_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_pointer_ff  <= mcuict_pkg::STK_RESET;
      data_pointer16_ff <= 16'h0000;
    end else begin
      stack_pointer_ff  <= nxt_stack;
      data_pointer16_ff <= nxt_dp;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/mcuict_top.sv */
// instruction timing sequencer: takes an opcode, holds it for its cycles
// assumes issue only while ready is high; one system clock
`timescale 1ns/100ps
`default_nettype none
module mcuict_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // instruction issue
  input  wire logic        issue_valid,
  input  wire logic [7:0]  issue_opcode,
  input  wire logic [15:0] issue_dp_value,
  // timing answer
  output logic             ready_ff,
  output logic             done_ff,
  output logic [1:0]       len_ff,
  output logic [3:0]       cycles_ff,
  output logic             illegal_ff,
  // pointers
  output logic [7:0]       stack_pointer,
  output logic [15:0]      data_pointer16
);
  mcuict_pkg::mcuict_state_t state_ff;
  mcuict_pkg::mcuict_state_t nxt_state;
  logic [3:0] count_ff;
  logic [3:0] nxt_count;
  logic [1:0] t_len;
  logic [3:0] t_cyc;
  logic       t_known;
  logic [7:0] stack_q;
  logic [15:0] dp_q;

  mcuict_table u_table (
    .opcode     (issue_opcode),
    .len_bytes  (t_len),
    .num_cycles (t_cyc),
    .known      (t_known)
  );

  wire take    = issue_valid && ready_ff;
  wire op_push = take && issue_opcode == mcuict_pkg::OP_PUSH;
  wire op_pop  = take && issue_opcode == mcuict_pkg::OP_POP;
  wire op_dinc = take && issue_opcode == mcuict_pkg::OP_INC_DP;
  wire op_dld  = take && issue_opcode == mcuict_pkg::OP_MOV_DP;
  wire last    = state_ff == mcuict_pkg::MCUICT_BUSY
                 && count_ff == mcuict_pkg::CYC1;

  mcuict_ptrs u_ptrs (
    .clk               (clk),
    .rst               (rst),
    .push_go           (op_push),
    .pop_go            (op_pop),
    .dp_inc            (op_dinc),
    .dp_load           (op_dld),
    .dp_value          (issue_dp_value),
    .stack_pointer_ff  (stack_q),
    .data_pointer16_ff (dp_q)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    unique case (state_ff)
      mcuict_pkg::MCUICT_IDLE: begin
        if (take) begin
          nxt_state = mcuict_pkg::MCUICT_BUSY;
          nxt_count = t_cyc;
        end
      end
      mcuict_pkg::MCUICT_BUSY: begin
        if (count_ff == mcuict_pkg::CYC1) begin
          nxt_state = mcuict_pkg::MCUICT_IDLE;
        end else begin
          nxt_count = count_ff - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= mcuict_pkg::MCUICT_IDLE;
      count_ff   <= 4'h0;
      ready_ff   <= 1'b1;
      done_ff    <= 1'b0;
      len_ff     <= 2'h0;
      cycles_ff  <= 4'h0;
      illegal_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      ready_ff <= (nxt_state == mcuict_pkg::MCUICT_IDLE);
      done_ff  <= last;
      if (take) begin
        len_ff     <= t_len;
        cycles_ff  <= t_cyc;
        illegal_ff <= !t_known;
      end
    end
  end

  assign stack_pointer  = stack_q;
  assign data_pointer16 = dp_q;
endmodule
`default_nettype wire

/* File: dv/mcuict_assertions.sv */
// checker: timing and pointer properties of the instruction sequencer
// assumes it is bound to mcuict_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module mcuict_top_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // issue
  input wire logic        issue_valid,
  input wire logic [7:0]  issue_opcode,
  input wire logic [15:0] issue_dp_value,
  // answer and pointers
  input wire logic        ready_ff,
  input wire logic        done_ff,
  input wire logic [1:0]  len_ff,
  input wire logic [3:0]  cycles_ff,
  input wire logic        illegal_ff,
  input wire logic [7:0]  stack_pointer,
  input wire logic [15:0] data_pointer16
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic       take;
  logic [4:0] busy_cnt_ff;
  logic [4:0] nxt_busy_cnt;
  assign take = issue_valid && ready_ff;
  assign nxt_busy_cnt = take ? 5'h01
                      : (ready_ff ? 5'h00 : busy_cnt_ff + 5'h01);
  always_ff @(posedge clk) begin
    if (rst) busy_cnt_ff <= 5'h00;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  sequence s_take(logic [7:0] op);
    issue_valid && ready_ff && issue_opcode == op;
  endsequence
  AST_TAKE_BUSY: assert property (
    take |=> !ready_ff && !done_ff)
    else $error("ready stayed high after a take");
  AST_DONE_COUNT: assert property (
    done_ff |-> busy_cnt_ff == {1'b0, cycles_ff} + 5'h01)
    else $error("done came after the wrong number of cycles");
  AST_DONE_PULSE: assert property (
    done_ff |=> !done_ff)
    else $error("done longer than one cycle");
  // a reset in mid-instruction raises ready without done
  AST_READY_DONE: assert property (
    $rose(ready_ff) && !$past(rst) |-> done_ff)
    else $error("ready returned without done");
  AST_CPL_ONE: assert property (
    s_take(mcuict_pkg::OP_CPL_A) |=>
      (len_ff == mcuict_pkg::LEN1 && cycles_ff == mcuict_pkg::CYC1)
      ##1 done_ff)
    else $error("complement timing wrong");
  AST_MOVD_THREE: assert property (
    s_take(mcuict_pkg::OP_MOVD_D) |=>
      (len_ff == mcuict_pkg::LEN3 && !done_ff) ##2 !done_ff ##1 done_ff)
    else $error("direct move timing wrong");
  AST_PUSH_STACK: assert property (
    s_take(mcuict_pkg::OP_PUSH) |=>
      stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("push did not step the stack pointer up");
  AST_POP_STACK: assert property (
    s_take(mcuict_pkg::OP_POP) |=>
      stack_pointer == $past(stack_pointer) - 8'h01)
    else $error("pop did not step the stack pointer down");
  AST_DP_INC: assert property (
    s_take(mcuict_pkg::OP_INC_DP) |=>
      data_pointer16 == $past(data_pointer16) + 16'h0001)
    else $error("data pointer increment wrong");
  AST_DP_LOAD: assert property (
    s_take(mcuict_pkg::OP_MOV_DP) |=>
      data_pointer16 == $past(issue_dp_value))
    else $error("data pointer load wrong");
  AST_BUSY_HOLD: assert property (
    !ready_ff |=> $stable(len_ff) && $stable(stack_pointer))
    else $error("issue taken while busy");
  // opcodes outside the table answer one byte, one cycle
  AST_ILLEGAL_ONE: assert property (
    illegal_ff |-> len_ff == mcuict_pkg::LEN1
                   && cycles_ff == mcuict_pkg::CYC1)
    else $error("unknown opcode timing wrong");
endmodule
bind mcuict_top mcuict_top_checker u_chk (.clk(clk), .rst(rst),
  .issue_valid(issue_valid), .issue_opcode(issue_opcode),
  .issue_dp_value(issue_dp_value), .ready_ff(ready_ff), .done_ff(done_ff),
  .len_ff(len_ff), .cycles_ff(cycles_ff), .illegal_ff(illegal_ff),
  .stack_pointer(stack_pointer), .data_pointer16(data_pointer16));
`default_nettype wire

/* File: dv/mcuict_code_mem.sv */
// program memory model: serves the two immediate bytes after an opcode
// assumes the bench presents the code address of the instruction
`timescale 1ns/100ps
`default_nettype none
module mcuict_code_mem (
  // fetch address
  input wire logic [7:0] code_addr,
  // immediate bytes, high byte first
  output logic [15:0]    imm16
);
  assign imm16 = {code_addr, ~code_addr};
endmodule
`default_nettype wire

/* File: dv/mcu_instruction_cycle_timing_tb.sv */
// self-checking bench for the instruction timing sequencer
// assumes mcuict_top, its package, the checker and the code memory model
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_cycle_timing_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        issue_valid = 1'b0;
  logic [7:0]  issue_opcode = 8'h00;
  logic [7:0]  code_addr = 8'h00;
  logic [15:0] imm16;
  logic        ready_ff;
  logic        done_ff;
  logic        illegal_ff;
  logic [1:0]  len_ff;
  logic [3:0]  cycles_ff;
  logic [7:0]  stack_pointer;
  logic [15:0] data_pointer16;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc_count = 0;
  int          n;
  // opcode, illegal bit 7, length 5:4, cycles 3:0
  logic [15:0] rows [48] = '{
    16'h3811, 16'h9811, 16'hc811,
    16'h2522, 16'h3522, 16'h9522, 16'h2422, 16'h3422,
    16'h2612, 16'hf612, 16'hd612,
    16'h0522, 16'h1522, 16'h0612, 16'h1612,
    16'ha311, 16'h3311, 16'h1311, 16'hf411,
    16'h5333, 16'h4333, 16'h6333, 16'h5222, 16'h4222, 16'h6222,
    16'h8533, 16'h9033, 16'h9313, 16'h8313,
    16'he213, 16'hf213, 16'he013, 16'hf013,
    16'hc022, 16'hd022, 16'hc222, 16'hd222, 16'hb222,
    16'hc311, 16'hd311, 16'hb311, 16'h0011, 16'h8091,
    16'h7422, 16'h7391, 16'hb491, 16'ha414, 16'h8418};
  always #4 clk = ~clk;
  mcuict_code_mem u_mem (.code_addr(code_addr), .imm16(imm16));
  mcuict_top dut (.clk(clk), .rst(rst), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .issue_dp_value(imm16),
    .ready_ff(ready_ff), .done_ff(done_ff), .len_ff(len_ff),
    .cycles_ff(cycles_ff), .illegal_ff(illegal_ff),
    .stack_pointer(stack_pointer), .data_pointer16(data_pointer16));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // issue one opcode and count cycles until done
  task automatic run(input logic [7:0] op);
    issue_valid = 1'b1;
    issue_opcode = op;
    @(posedge clk);
    #1 issue_valid = 1'b0;
    n = 1;
    while (done_ff !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    n = n - 1;
  endtask
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 chk(ready_ff, 1'b1);
    chk(stack_pointer, 8'h07);
    chk(data_pointer16, 16'h0000);
    rst = 1'b0;
    foreach (rows[i]) begin
      run(rows[i][15:8]);
      chk(len_ff, rows[i][5:4]);
      chk(cycles_ff, rows[i][3:0]);
      chk(n[15:0], rows[i][3:0]);
      chk(illegal_ff, rows[i][7]);
    end
    chk(stack_pointer, 8'h07);
    chk(data_pointer16, 16'h00ff);
    run(8'ha3);
    chk(data_pointer16, 16'h0100);
    // second load from a different code address
    code_addr = 8'h5a;
    run(8'h90);
    chk(data_pointer16, 16'h5aa5);
    // push offered while busy must be ignored
    issue_valid = 1'b1;
    issue_opcode = 8'h85;
    @(posedge clk);
    #1 issue_opcode = 8'hc0;
    @(posedge clk);
    #1 issue_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(done_ff, 1'b1);
    chk(stack_pointer, 8'h07);
    run(8'hc0);
    chk(stack_pointer, 8'h08);
    // reset in the middle of a long instruction
    issue_valid = 1'b1;
    issue_opcode = 8'h53;
    @(posedge clk);
    #1 issue_valid = 1'b0;
    rst = 1'b1;
    @(posedge clk);
    #1 chk(ready_ff, 1'b1);
    chk(stack_pointer, 8'h07);
    chk(len_ff, 2'h0);
    chk(cycles_ff, 4'h0);
    chk(data_pointer16, 16'h0000);
    rst = 1'b0;
    run(8'hf4);
    chk(n[15:0], 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
